// >>> design/ldc_pkg.sv
// Constants shared by the latch delay correction block
package ldc_pkg;

    // ------------------------------------------------------------
    // Object indices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_CORR_A = 16'h3709;
    localparam logic [15:0] IDX_SETUP_C = 16'h3724;
    localparam logic [15:0] IDX_CORR_B = 16'h3792;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SETUP_C_EDGE_SEL_BIT = 5;
    localparam int PFC_START_BIT = 0;
    localparam int PFC_TRIG_SEL_BIT = 2;
    localparam int PFC_RISE_EN_BIT = 4;
    localparam int PFC_FALL_EN_BIT = 5;
    localparam int PFC_CH_STRIDE = 8;
    localparam int PSE_ZSRC_BIT = 0;
    localparam int PSE_FBSRC_BIT = 1;
    localparam int PSE_CH_STRIDE = 8;
    localparam int SMS_MONITOR_BIT = 4;
    localparam int FE3_SCALE_LATCH_BIT = 11;

    // ------------------------------------------------------------
    // Correction range and timing
    // ------------------------------------------------------------
    localparam logic signed [15:0] CORR_MIN = -16'sd2000;
    localparam logic signed [15:0] CORR_MAX = 16'sd2000;
    localparam int CORR_STEP_NS = 25;
    localparam int CLK_PERIOD_NS = 8;
    // Velocity input is in counts per 2**VEL_SHIFT correction steps
    localparam int VEL_SHIFT = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
    localparam logic [15:0] CORR_RESET = 16'h0000;

endpackage : ldc_pkg

// >>> design/ldc_edge.sv
// Rising and falling edge detector for one latch trigger
`timescale 1ns/100ps
module ldc_edge (
    input wire logic clock,
    input wire logic resetn,
    input wire logic trig_on,
    output logic rise,
    output logic fall
);

    logic prev_reg;
    logic prev_next;
    logic rise_reg;
    logic rise_next;
    logic fall_reg;
    logic fall_next;

    always_comb begin
        prev_next = trig_on;
        rise_next = trig_on & ~prev_reg;
        fall_next = ~trig_on & prev_reg;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            // Starts as off so an input already on at reset reads as a rise
            prev_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign rise = rise_reg;
    assign fall = fall_reg;

endmodule : ldc_edge

// >>> design/ldc_comp.sv
// Delay compensation of one latched position
`timescale 1ns/100ps
module ldc_comp #(
    parameter int POS_W = 32
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    input wire logic signed [POS_W-1:0] pos,
    input wire logic signed [POS_W-1:0] vel,
    input wire logic signed [15:0] corr,
    output logic signed [POS_W-1:0] comp_pos,
    output logic done
);

    localparam int PROD_W = POS_W + 16;

    logic signed [15:0] corr_sat;
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] shifted;
    logic signed [POS_W-1:0] pos_reg;
    logic signed [POS_W-1:0] pos_next;
    logic done_reg;
    logic done_next;

    initial begin
        if (POS_W < 17) begin
            $error("ldc_comp: POS_W must be at least 17");
        end
    end

    always_comb begin
        // Out-of-range settings are held at the limits
        if (corr > ldc_pkg::CORR_MAX) begin
            corr_sat = ldc_pkg::CORR_MAX;
        end else if (corr < ldc_pkg::CORR_MIN) begin
            corr_sat = ldc_pkg::CORR_MIN;
        end else begin
            corr_sat = corr;
        end
        prod = PROD_W'(vel) * PROD_W'(corr_sat);
        shifted = prod >>> ldc_pkg::VEL_SHIFT;
        // Positive time: true edge came earlier, so motion is taken off
        pos_next = start ? pos - shifted[POS_W-1:0] : pos_reg;
        done_next = start;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pos_reg <= POS_W'(ldc_pkg::POS_RESET);
            done_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            done_reg <= done_next;
        end
    end

    assign comp_pos = pos_reg;
    assign done = done_reg;

endmodule : ldc_comp

// >>> design/ldc_top.sv
// Touch probe latch with detection delay correction and scale Z checks
`timescale 1ns/100ps
module ldc_top #(
    parameter int POS_W = 32
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [15:0] latch_delay_correction_a,
    input wire logic [15:0] comm_extended_setup_c,
    input wire logic [15:0] latch_delay_correction_b,
    input wire logic [15:0] probe_function_control,
    input wire logic [15:0] probe_source_extension,
    input wire logic [15:0] scale_monitor_setup,
    input wire logic [15:0] function_expansion_three,
    input wire logic semi_closed,
    input wire logic scale_ab_type,
    input wire logic [1:0] ext_trig_on,
    input wire logic enc_z,
    input wire logic scale_z,
    input wire logic [POS_W-1:0] enc_pos,
    input wire logic [POS_W-1:0] scale_pos,
    input wire logic [POS_W-1:0] enc_vel,
    input wire logic [POS_W-1:0] scale_vel,
    input wire logic homing_start,
    input wire logic error_clear,
    output logic command_config_error,
    output logic [POS_W-1:0] probe_one_rising_position,
    output logic [POS_W-1:0] probe_one_falling_position,
    output logic [POS_W-1:0] probe_two_rising_position,
    output logic [POS_W-1:0] probe_two_falling_position,
    output logic [3:0] position_update,
    output logic [1:0] position_in_scale_units,
    output logic scale_z_active
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    initial begin
        if (POS_W < 17 || POS_W > 64) begin
            $error("ldc_top: POS_W must lie in 17..64");
        end
    end

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    logic edge_sel;
    logic scale_z_ok;
    logic [1:0] ch_start;
    logic [1:0] ch_trig_z;
    logic [1:0] ch_rise_en;
    logic [1:0] ch_fall_en;
    logic [1:0] ch_zsrc;
    logic [1:0] ch_fbsrc;

    always_comb begin
        edge_sel = comm_extended_setup_c[ldc_pkg::SETUP_C_EDGE_SEL_BIT];
        // Scale Z only counts under semi-closed with both the monitor and scale latch bits set
        scale_z_ok = semi_closed
            & scale_monitor_setup[ldc_pkg::SMS_MONITOR_BIT]
            & function_expansion_three[ldc_pkg::FE3_SCALE_LATCH_BIT];
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_dec
            localparam int PB = g * ldc_pkg::PFC_CH_STRIDE;
            localparam int SB = g * ldc_pkg::PSE_CH_STRIDE;
            assign ch_start[g] =
                probe_function_control[PB + ldc_pkg::PFC_START_BIT];
            assign ch_trig_z[g] =
                probe_function_control[PB + ldc_pkg::PFC_TRIG_SEL_BIT];
            assign ch_rise_en[g] =
                probe_function_control[PB + ldc_pkg::PFC_RISE_EN_BIT];
            assign ch_fall_en[g] =
                probe_function_control[PB + ldc_pkg::PFC_FALL_EN_BIT];
            assign ch_zsrc[g] =
                probe_source_extension[SB + ldc_pkg::PSE_ZSRC_BIT];
            assign ch_fbsrc[g] =
                probe_source_extension[SB + ldc_pkg::PSE_FBSRC_BIT];
        end
    endgenerate

    // ------------------------------------------------------------
    // Per-channel trigger, capture and compensation
    // ------------------------------------------------------------
    logic [1:0] rise_det;
    logic [1:0] fall_det;
    logic [1:0] comp_start;
    logic [1:0] comp_done;
    logic [1:0] use_scale;
    logic [POS_W-1:0] comp_pos [2];
    logic [POS_W-1:0] src_pos [2];
    logic [POS_W-1:0] src_vel [2];
    logic [15:0] eff_corr [2];
    logic [1:0] pend_fall_reg;
    logic [1:0] pend_fall_next;
    logic [1:0] pend_scale_reg;
    logic [1:0] pend_scale_next;

    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic z_line;
            logic trig_line;

            // Scale Z replaces encoder Z only when fully enabled
            assign z_line = (scale_z_ok & ch_zsrc[g]) ? scale_z : enc_z;
            assign trig_line = ch_trig_z[g] ? z_line : ext_trig_on[g];
            // Scale feedback goes to the latch only under semi-closed
            assign use_scale[g] = semi_closed & ch_fbsrc[g];
            assign src_pos[g] = use_scale[g] ? scale_pos : enc_pos;
            assign src_vel[g] = use_scale[g] ? scale_vel : enc_vel;

            ldc_edge u_edge (
                .clock(clock),
                .resetn(resetn),
                .trig_on(trig_line),
                .rise(rise_det[g]),
                .fall(fall_det[g])
            );

            assign comp_start[g] = ch_start[g]
                & ((rise_det[g] & ch_rise_en[g])
                | (fall_det[g] & ch_fall_en[g]));

            // Second value is ignored unless the select bit is set
            assign eff_corr[g] = (fall_det[g] & edge_sel)
                ? latch_delay_correction_b
                : latch_delay_correction_a;

            ldc_comp #(
                .POS_W(POS_W)
            ) u_comp (
                .clock(clock),
                .resetn(resetn),
                .start(comp_start[g]),
                .pos(src_pos[g]),
                .vel(src_vel[g]),
                .corr(eff_corr[g]),
                .comp_pos(comp_pos[g]),
                .done(comp_done[g])
            );
        end
    endgenerate

    // Edge type and unit travel alongside the compensation stage
    always_comb begin
        pend_fall_next = pend_fall_reg;
        pend_scale_next = pend_scale_reg;
        for (int i = 0; i < 2; i++) begin
            if (comp_start[i]) begin
                pend_fall_next[i] = fall_det[i];
                pend_scale_next[i] = use_scale[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pend_fall_reg <= 2'h0;
            pend_scale_reg <= 2'h0;
        end else begin
            pend_fall_reg <= pend_fall_next;
            pend_scale_reg <= pend_scale_next;
        end
    end

    // ------------------------------------------------------------
    // Latched position registers
    // ------------------------------------------------------------
    logic [POS_W-1:0] pos_reg [4];
    logic [POS_W-1:0] pos_next [4];
    logic [3:0] upd_reg;
    logic [3:0] upd_next;
    logic [1:0] unit_reg;
    logic [1:0] unit_next;

    // Index: 2*channel + edge, edge 0 rising, 1 falling
    always_comb begin
        upd_next = 4'h0;
        unit_next = unit_reg;
        for (int k = 0; k < 4; k++) begin
            pos_next[k] = pos_reg[k];
        end
        for (int i = 0; i < 2; i++) begin
            if (comp_done[i]) begin
                pos_next[2 * i + int'(pend_fall_reg[i])] = comp_pos[i];
                upd_next[2 * i + int'(pend_fall_reg[i])] = 1'b1;
                unit_next[i] = pend_scale_reg[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int k = 0; k < 4; k++) begin
                pos_reg[k] <= POS_W'(ldc_pkg::POS_RESET);
            end
            upd_reg <= 4'h0;
            unit_reg <= 2'h0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                pos_reg[k] <= pos_next[k];
            end
            upd_reg <= upd_next;
            unit_reg <= unit_next;
        end
    end

    // ------------------------------------------------------------
    // Command configuration checks
    // ------------------------------------------------------------
    logic [1:0] start_prev_reg;
    logic [1:0] start_prev_next;
    logic err_reg;
    logic err_next;
    logic zact_reg;
    logic zact_next;
    logic activate;
    logic err_set;

    always_comb begin
        start_prev_next = ch_start;
        // Only a stop-to-start change imports the settings
        activate = |(ch_start & ~start_prev_reg);
        err_set = 1'b0;
        if (activate && scale_ab_type) begin
            if (ch_zsrc[0] != ch_zsrc[1]) begin
                err_set = 1'b1;
            end
            if ((&ch_zsrc) && !(&ch_trig_z)) begin
                err_set = 1'b1;
            end
        end
        if (homing_start && (|ch_zsrc)) begin
            err_set = 1'b1;
        end
        // A new fault in the clearing cycle stays set
        if (err_set) begin
            err_next = 1'b1;
        end else if (error_clear) begin
            err_next = 1'b0;
        end else begin
            err_next = err_reg;
        end
        zact_next = scale_z_ok & (|ch_zsrc);
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            start_prev_reg <= 2'h0;
            err_reg <= 1'b0;
            zact_reg <= 1'b0;
        end else begin
            start_prev_reg <= start_prev_next;
            err_reg <= err_next;
            zact_reg <= zact_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign command_config_error = err_reg;
    assign probe_one_rising_position = pos_reg[0];
    assign probe_one_falling_position = pos_reg[1];
    assign probe_two_rising_position = pos_reg[2];
    assign probe_two_falling_position = pos_reg[3];
    assign position_update = upd_reg;
    assign position_in_scale_units = unit_reg;
    assign scale_z_active = zact_reg;

endmodule : ldc_top

// >>> testbench/ldc_far_model.sv
// Far side model: trigger photocoupler and position sources
`timescale 1ns/100ps
module ldc_far_model #(
    parameter logic [31:0] ENC_POS = 32'h0001_0000,
    parameter logic [31:0] SCALE_POS = 32'h0020_0000,
    parameter logic [31:0] ENC_VEL = 32'h0001_0000,
    parameter logic [31:0] SCALE_VEL = 32'h0002_0000
) (
    input wire logic [1:0] trig_req,
    output logic [1:0] ext_trig_on,
    output logic [31:0] enc_pos,
    output logic [31:0] scale_pos,
    output logic [31:0] enc_vel,
    output logic [31:0] scale_vel
);
    // ------------------------------------------------------------
    // Sources
    // ------------------------------------------------------------
    // Positions and velocities held constant so the latched value is known exactly
    assign ext_trig_on = trig_req;
    assign enc_pos = ENC_POS;
    assign scale_pos = SCALE_POS;
    assign enc_vel = ENC_VEL;
    assign scale_vel = SCALE_VEL;
endmodule : ldc_far_model

// >>> testbench/ldc_top_props.sv
// Port-level checks of the latch delay correction block
`timescale 1ns/100ps
module ldc_top_props (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [15:0] probe_function_control,
    input wire logic [15:0] probe_source_extension,
    input wire logic [15:0] scale_monitor_setup,
    input wire logic [15:0] function_expansion_three,
    input wire logic semi_closed,
    input wire logic scale_ab_type,
    input wire logic [1:0] ext_trig_on,
    input wire logic homing_start,
    input wire logic error_clear,
    input wire logic command_config_error,
    input wire logic [3:0] position_update,
    input wire logic [1:0] position_in_scale_units,
    input wire logic scale_z_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Latch edges
    // ------------------------------------------------------------
    property p_rise1;
        $rose(ext_trig_on[0]) && probe_function_control[0]
            && probe_function_control[4] && !probe_function_control[2]
            |-> ##[3:4] position_update[0];
    endproperty
    a_rise1: assert property (p_rise1) else $error("missed rise latch");
    property p_fall1;
        $fell(ext_trig_on[0]) && probe_function_control[0]
            && probe_function_control[5] && !probe_function_control[2]
            |-> ##[3:4] position_update[1];
    endproperty
    a_fall1: assert property (p_fall1) else $error("missed fall latch");
    property p_rise2;
        $rose(ext_trig_on[1]) && probe_function_control[8]
            && probe_function_control[12] && !probe_function_control[10]
            |-> ##[3:4] position_update[2];
    endproperty
    a_rise2: assert property (p_rise2) else $error("missed ch2 latch");
    property p_upd_start;
        position_update[0] |-> $past(probe_function_control[0], 2);
    endproperty
    a_upd_start: assert property (p_upd_start) else $error("stopped latch");
    property p_units;
        $rose(position_in_scale_units[1])
            |-> $past(semi_closed, 2) && $past(probe_source_extension[9], 2);
    endproperty
    a_units: assert property (p_units) else $error("bad unit flag");
    // ------------------------------------------------------------
    // Configuration errors and scale Z enable
    // ------------------------------------------------------------
    property p_err_src;
        scale_ab_type && $rose(probe_function_control[0])
            && (probe_source_extension[0] != probe_source_extension[8])
            |-> ##[1:2] command_config_error;
    endproperty
    a_err_src: assert property (p_err_src) else $error("no source error");
    property p_err_trig;
        scale_ab_type && $rose(probe_function_control[0])
            && probe_source_extension[0] && probe_source_extension[8]
            && !(probe_function_control[2] && probe_function_control[10])
            |-> ##[1:2] command_config_error;
    endproperty
    a_err_trig: assert property (p_err_trig) else $error("no select error");
    property p_err_home;
        homing_start && (probe_source_extension[0] || probe_source_extension[8])
            |-> ##[1:2] command_config_error;
    endproperty
    a_err_home: assert property (p_err_home) else $error("no homing error");
    property p_err_hold;
        command_config_error && !error_clear |=> command_config_error;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error dropped");
    property p_scale_z;
        scale_z_active |-> $past(semi_closed) && $past(scale_monitor_setup[4])
            && $past(function_expansion_three[11]);
    endproperty
    a_scale_z: assert property (p_scale_z) else $error("scale Z enabled");
endmodule : ldc_top_props

bind ldc_top ldc_top_props u_ldc_top_props (
    .clock(clock), .resetn(resetn),
    .probe_function_control(probe_function_control),
    .probe_source_extension(probe_source_extension),
    .scale_monitor_setup(scale_monitor_setup),
    .function_expansion_three(function_expansion_three),
    .semi_closed(semi_closed), .scale_ab_type(scale_ab_type),
    .ext_trig_on(ext_trig_on), .homing_start(homing_start),
    .error_clear(error_clear), .command_config_error(command_config_error),
    .position_update(position_update),
    .position_in_scale_units(position_in_scale_units),
    .scale_z_active(scale_z_active)
);

// >>> testbench/ldc_top_tb_top.sv
// Self-checking bench for the latch delay correction block
`timescale 1ns/100ps
module ldc_top_tb_top;
    localparam logic [31:0] ENC = 32'h0001_0000;
    localparam logic [31:0] SCL = 32'h0020_0000;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] corr_a = 16'h0000;
    logic [15:0] setup_c = 16'h0000;
    logic [15:0] corr_b = 16'h0000;
    logic [15:0] pfc = 16'h0000;
    logic [15:0] pse = 16'h0000;
    logic [15:0] sms = 16'h0000;
    logic [15:0] fe3 = 16'h0000;
    logic semi = 1'b0;
    logic ab = 1'b0;
    logic homing = 1'b0;
    logic err_clr = 1'b0;
    logic enc_z = 1'b0;
    logic scale_z = 1'b0;
    logic [1:0] trig_req = 2'h0;
    logic [1:0] trig_on;
    logic [31:0] enc_pos, scale_pos, enc_vel, scale_vel;
    logic [31:0] pos [4];
    logic [3:0] upd;
    logic [1:0] units;
    logic err;
    logic szact;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    ldc_far_model u_ldc_far_model (.trig_req(trig_req), .ext_trig_on(trig_on),
        .enc_pos(enc_pos), .scale_pos(scale_pos), .enc_vel(enc_vel),
        .scale_vel(scale_vel));
    ldc_top #(.POS_W(32)) u_ldc_top (.clock(clock), .resetn(resetn),
        .latch_delay_correction_a(corr_a), .comm_extended_setup_c(setup_c),
        .latch_delay_correction_b(corr_b), .probe_function_control(pfc),
        .probe_source_extension(pse), .scale_monitor_setup(sms),
        .function_expansion_three(fe3), .semi_closed(semi),
        .scale_ab_type(ab), .ext_trig_on(trig_on), .enc_z(enc_z),
        .scale_z(scale_z), .enc_pos(enc_pos), .scale_pos(scale_pos),
        .enc_vel(enc_vel), .scale_vel(scale_vel), .homing_start(homing),
        .error_clear(err_clr), .command_config_error(err),
        .probe_one_rising_position(pos[0]),
        .probe_one_falling_position(pos[1]),
        .probe_two_rising_position(pos[2]),
        .probe_two_falling_position(pos[3]), .position_update(upd),
        .position_in_scale_units(units), .scale_z_active(szact));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        forever #4 clock = ~clock;
    end
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    // Waits on the update pulse, then reads the slot it names
    task automatic trig(input int ch, input logic lvl, input int slot,
                        input logic [31:0] exp);
        int n;
        n = 0;
        @(negedge clock);
        trig_req[ch] = lvl;
        while (upd[slot] !== 1'b1 && n < 10) begin
            @(negedge clock);
            n++;
        end
        check(upd[slot], 1'b1);
        check(pos[slot], exp);
    endtask : trig
    // Activation with a setting, then a clear with the cause gone
    task automatic cfg(input logic [15:0] p, input logic [15:0] s,
                       input logic exp);
        @(negedge clock);
        pse = s;
        pfc = p;
        cyc(3);
        check(err, exp);
        pfc = 16'h0000;
        err_clr = 1'b1;
        cyc(2);
        err_clr = 1'b0;
        check(err, 1'b0);
    endtask : cfg

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        cyc(6);
        resetn = 1'b1;
        cyc(2);
        corr_a = 16'h0064;
        corr_b = 16'hFFCE;
        pfc = 16'h0031;
        cyc(2);
        trig(0, 1'b1, 0, ENC - 32'd100);
        trig(0, 1'b0, 1, ENC - 32'd100);
        setup_c = 16'h0020;
        trig(0, 1'b1, 0, ENC - 32'd100);
        trig(0, 1'b0, 1, ENC + 32'd50);
        setup_c = 16'h0000;
        corr_a = 16'h0BB8;
        trig(0, 1'b1, 0, ENC - 32'd2000);
        corr_a = 16'hF448;
        trig(0, 1'b0, 1, ENC + 32'd2000);
        corr_a = 16'h0064;
        semi = 1'b1;
        pse = 16'h0200;
        pfc = 16'h3100;
        cyc(2);
        trig(1, 1'b1, 2, SCL - 32'd200);
        check(units[1], 1'b1);
        trig(1, 1'b0, 3, SCL - 32'd200);
        sms = 16'h0010;
        fe3 = 16'h0800;
        pse = 16'h0001;
        cyc(2);
        check(szact, 1'b1);
        sms = 16'h0000;
        cyc(2);
        check(szact, 1'b0);
        // Z-phase trigger: scale Z only counts once fully enabled
        pfc = 16'h0015;
        pse = 16'h0003;
        scale_z = 1'b1;
        cyc(3);
        check(upd[0], 1'b0);
        enc_z = 1'b1;
        cyc(3);
        check(upd[0], 1'b1);
        enc_z = 1'b0;
        scale_z = 1'b0;
        sms = 16'h0010;
        cyc(2);
        scale_z = 1'b1;
        cyc(3);
        check(upd[0], 1'b1);
        check(pos[0], SCL - 32'd200);
        check(units[0], 1'b1);
        scale_z = 1'b0;
        sms = 16'h0000;
        pfc = 16'h0000;
        ab = 1'b1;
        cyc(2);
        cfg(16'h0101, 16'h0001, 1'b1);
        cfg(16'h0101, 16'h0000, 1'b0);
        cfg(16'h0101, 16'h0101, 1'b1);
        cfg(16'h0505, 16'h0101, 1'b0);
        for (int i = 0; i < 2; i++) begin
            pse = (i == 0) ? 16'h0100 : 16'h0000;
            homing = 1'b1;
            cyc(1);
            homing = 1'b0;
            cyc(2);
            check(err, (i == 0));
            err_clr = 1'b1;
            cyc(2);
            err_clr = 1'b0;
        end
        end_sim();
    end
endmodule : ldc_top_tb_top
